// [sshc_top.sv]
// Synchronous half-duplex serial engine with AHB-Lite register slave
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module sshc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Clock line pin
    input wire logic clock_line_in,
    output logic clock_line_out,
    output logic clock_line_oe,
    // Data line pin
    input wire logic data_line_in,
    output logic data_line_out,
    output logic data_line_oe
);
    // ****************
    // Register slave
    // ****************
    logic [sshc_pkg::CTRL_W-1:0] ctrl;
    logic [15:0] baud_div;
    logic ph_write;
    logic ph_read;
    logic [7:0] ph_addr;
    wire take = hsel && hready && (htrans == sshc_pkg::HTRANS_NONSEQ);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ph_write <= 1'b0;
            ph_read <= 1'b0;
            ph_addr <= 8'h00;
        end
        else if (hready)
        begin
            ph_write <= take && hwrite;
            ph_read <= take && !hwrite;
            ph_addr <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire wr_ctrl = ph_write && (ph_addr == sshc_pkg::ADDR_CTRL);
    wire wr_txd = ph_write && (ph_addr == sshc_pkg::ADDR_TXD);
    wire wr_baud = ph_write && (ph_addr == sshc_pkg::ADDR_BAUD);
    wire rd_rxd = ph_read && (ph_addr == sshc_pkg::ADDR_RXD);

    wire serial_port_enable = ctrl[sshc_pkg::C_SERIAL_PORT_ENABLE];
    wire host = ctrl[sshc_pkg::C_CLOCK_SOURCE_SELECT];
    wire cpol = ctrl[sshc_pkg::C_CPOL];
    wire transmit_enable = ctrl[sshc_pkg::C_TRANSMIT_ENABLE];
    wire tx9 = ctrl[sshc_pkg::C_TX9];
    wire transmit_ninth_bit = ctrl[sshc_pkg::C_TRANSMIT_NINTH_BIT];
    wire rx9 = ctrl[sshc_pkg::C_RX9];
    wire single_receive_enable = ctrl[sshc_pkg::C_SINGLE_RECEIVE_ENABLE];
    wire continuous_receive_enable = ctrl[sshc_pkg::C_CONTINUOUS_RECEIVE_ENABLE];
    wire rx_mode = single_receive_enable || continuous_receive_enable;

    // ****************
    // Pin inputs and edges
    // ****************
    logic ck_s;
    logic dt_s;
    logic ck_d;
    sshc_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({clock_line_in, data_line_in}),
        .sync_out({ck_s, dt_s})
    );
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ck_d <= 1'b0;
        else
            ck_d <= ck_s;
    end
    wire c_lead = (ck_d == cpol) && (ck_s != cpol);
    wire c_trail = (ck_d != cpol) && (ck_s == cpol);

    // ****************
    // Engine state
    // ****************
    sshc_pkg::sshc_state_type st;
    logic [15:0] bcnt;
    logic phase;
    logic sck;
    logic [3:0] bitcnt;
    logic [8:0] thr;
    logic thr_full;
    logic [8:0] transmit_shift_register;
    logic [8:0] receive_shift_register;
    logic dout;
    logic overrun_error_flag;
    logic [8:0] fifo [sshc_pkg::FIFO_DEPTH];
    logic wp;
    logic rp;
    logic [1:0] cnt;

    wire active = serial_port_enable && (st != sshc_pkg::ST_IDLE);
    wire tick = host && active && (bcnt == baud_div);
    // host clock from divider, client from pin
    wire lead = active && (host ? (tick && !phase) : c_lead);
    wire trail = active && (host ? (tick && phase) : c_trail);
    // only data bits, eight or nine
    wire [3:0] nbits = (st == sshc_pkg::ST_RX) ? (rx9 ? sshc_pkg::BITS9 : sshc_pkg::BITS8)
                                               : (tx9 ? sshc_pkg::BITS9 : sshc_pkg::BITS8);
    wire last = trail && (bitcnt == nbits - sshc_pkg::BIT_ONE);
    wire done = last && (st == sshc_pkg::ST_RX);
    // LSB first, so the last bit lands in the MSB
    wire [8:0] rsr_in = {dt_s, receive_shift_register[8:1]};
    wire [8:0] rx_char = rx9 ? rsr_in : {1'b0, rsr_in[8:1]};
    // holding moves when the shifter is free
    wire can_load = serial_port_enable && transmit_enable && !rx_mode && thr_full;
    wire load = can_load && ((st == sshc_pkg::ST_IDLE) || (last && st == sshc_pkg::ST_TX));
    wire full = (cnt == sshc_pkg::FIFO_FULL);
    wire push = done && !full && !overrun_error_flag;
    wire pop = rd_rxd && (cnt != 2'h0);
    wire ovr_set = done && (full || overrun_error_flag);
    wire continuous_receive_enable_fall = wr_ctrl && continuous_receive_enable && !hwdata[sshc_pkg::C_CONTINUOUS_RECEIVE_ENABLE];

    sshc_pkg::sshc_state_type next_st;
    always_comb
    begin
        next_st = st;
        case (st)
            sshc_pkg::ST_IDLE:
            begin
                if (serial_port_enable && rx_mode)
                    next_st = sshc_pkg::ST_RX;
                else if (load)
                    next_st = sshc_pkg::ST_TX;
            end
            sshc_pkg::ST_TX:
            begin
                if (last && !load)
                    next_st = sshc_pkg::ST_IDLE;
            end
            sshc_pkg::ST_RX:
            begin
                // clearing the enables aborts at once
                if (!rx_mode)
                    next_st = sshc_pkg::ST_IDLE;
                else if (done && single_receive_enable && !continuous_receive_enable)
                    next_st = sshc_pkg::ST_IDLE;
            end
            default: next_st = sshc_pkg::ST_IDLE;
        endcase
        if (!serial_port_enable)
            next_st = sshc_pkg::ST_IDLE;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            st <= sshc_pkg::ST_IDLE;
        else
            st <= next_st;
    end

    // ****************
    // Control registers
    // ****************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ctrl <= sshc_pkg::CTRL_RESET;
            baud_div <= sshc_pkg::BAUD_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= hwdata[sshc_pkg::CTRL_W-1:0];
            else if (done && single_receive_enable)
                ctrl[sshc_pkg::C_SINGLE_RECEIVE_ENABLE] <= 1'b0;
            if (wr_baud)
                baud_div <= hwdata[15:0];
        end
    end

    // ****************
    // Host clock generator
    // ****************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            bcnt <= sshc_pkg::BAUD_ZERO;
            phase <= 1'b0;
            sck <= 1'b0;
        end
        else if (!active)
        begin
            bcnt <= sshc_pkg::BAUD_ZERO;
            phase <= 1'b0;
            sck <= cpol;
        end
        else
        begin
            bcnt <= tick ? sshc_pkg::BAUD_ZERO : bcnt + 16'h0001;
            if (tick)
            begin
                phase <= !phase;
                sck <= phase ? cpol : !cpol;
            end
        end
    end

    // ****************
    // Shifters
    // ****************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !serial_port_enable)
        begin
            thr <= 9'h000;
            thr_full <= 1'b0;
            transmit_shift_register <= 9'h000;
            receive_shift_register <= 9'h000;
            bitcnt <= 4'h0;
            dout <= 1'b0;
        end
        else
        begin
            // write wins over the move out
            if (wr_txd)
            begin
                thr <= {transmit_ninth_bit, hwdata[7:0]};
                thr_full <= 1'b1;
            end
            else if (load)
                thr_full <= 1'b0;
            if (load)
                transmit_shift_register <= thr;
            // data changes on the leading edge only
            else if (lead && st == sshc_pkg::ST_TX)
            begin
                dout <= transmit_shift_register[0];
                transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
            end
            if (trail && st == sshc_pkg::ST_RX)
                receive_shift_register <= rsr_in;
            if (!active || load || last)
                bitcnt <= 4'h0;
            else if (trail)
                bitcnt <= bitcnt + sshc_pkg::BIT_ONE;
        end
    end

    // ****************
    // Receive FIFO
    // ****************
    genvar g;
    generate
        for (g = 0; g < sshc_pkg::FIFO_DEPTH; g++)
        begin : g_fifo
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                    fifo[g] <= 9'h000;
                else if (push && wp == g)
                    fifo[g] <= rx_char;
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !serial_port_enable)
        begin
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'h0;
            overrun_error_flag <= 1'b0;
        end
        else
        begin
            if (push)
                wp <= !wp;
            if (pop)
                rp <= !rp;
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
            if (ovr_set)
                overrun_error_flag <= 1'b1;
            else if (continuous_receive_enable_fall)
                overrun_error_flag <= 1'b0;
        end
    end

    // ****************
    // Outputs
    // ****************
    wire recv_flag = (cnt != 2'h0);
    wire [8:0] top = fifo[rp];
    wire [31:0] stat_word = {27'h0, st == sshc_pkg::ST_TX, thr_full, recv_flag, overrun_error_flag, recv_flag && top[8]};
    assign hrdata = !ph_read ? 32'h0
                  : (ph_addr == sshc_pkg::ADDR_CTRL) ? {23'h0, ctrl}
                  : (ph_addr == sshc_pkg::ADDR_STAT) ? stat_word
                  : (ph_addr == sshc_pkg::ADDR_RXD) ? {24'h0, recv_flag ? top[7:0] : 8'h00}
                  : (ph_addr == sshc_pkg::ADDR_BAUD) ? {16'h0, baud_div}
                  : 32'h0;
    assign clock_line_out = sck;
    assign clock_line_oe = serial_port_enable && host;
    // data driven only in transmit direction
    assign data_line_out = dout;
    assign data_line_oe = serial_port_enable && transmit_enable && !rx_mode;

    // ****************
    // Assertions
    // ****************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_IDLE_LEVEL: assert property (
        (!active && $past(!active) && $stable(cpol)) |-> clock_line_out == cpol)
        else $error("clock not at idle level");
    AST_TX_DRIVERS: assert property (
        (host && st == sshc_pkg::ST_TX && !rx_mode) |-> clock_line_oe && data_line_oe)
        else $error("host transmit drivers off");
    AST_LOAD_NOW: assert property (
        (wr_txd && st == sshc_pkg::ST_IDLE && transmit_enable && !rx_mode && serial_port_enable && $stable(ctrl)) |=> ##1 st == sshc_pkg::ST_TX)
        else $error("idle shifter did not take character");
    AST_DATA_EDGE: assert property (
        (serial_port_enable && !$stable(data_line_out)) |-> $past(lead))
        else $error("data changed off leading edge");
    AST_RX_NO_DRIVE: assert property (
        rx_mode |-> !data_line_oe)
        else $error("data driven while receiving");
    AST_SINGLE_CLEAR: assert property (
        (done && single_receive_enable && !continuous_receive_enable && !wr_ctrl) |=> !single_receive_enable && st == sshc_pkg::ST_IDLE)
        else $error("single receive did not end");
    AST_ABORT: assert property (
        (st == sshc_pkg::ST_RX && !rx_mode) |=> st == sshc_pkg::ST_IDLE ##1 clock_line_out == cpol)
        else $error("receive abort did not stop clock");
    AST_PUSH_FLAG: assert property (
        push |=> recv_flag && cnt == $past(cnt) + 2'h1 - {1'b0, $past(pop)})
        else $error("pushed character not counted");
    AST_CLIENT_CLK: assert property (
        !host |-> !clock_line_oe)
        else $error("client drives clock");
    AST_OVERRUN: assert property (
        (done && full && serial_port_enable) |=> overrun_error_flag && cnt == sshc_pkg::FIFO_FULL - {1'b0, $past(pop)})
        else $error("overrun not flagged");
    AST_OVR_CLEAR: assert property (
        (overrun_error_flag && continuous_receive_enable_fall && !ovr_set && serial_port_enable) |=> !overrun_error_flag)
        else $error("overrun not cleared");

    COV_TX: cover property (st == sshc_pkg::ST_TX ##[1:300] st == sshc_pkg::ST_IDLE);
    COV_RX_DONE: cover property (done && single_receive_enable);
    COV_OVR: cover property (ovr_set);
    COV_CLIENT: cover property (!host && done);
endmodule : sshc_top

// [sshc_pkg.sv]
// Constants, register map and types of the synchronous serial host/client engine
package sshc_pkg;
    // ****************
    // Register map
    // ****************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_TXD = 8'h08;
    localparam logic [7:0] ADDR_RXD = 8'h0C;
    localparam logic [7:0] ADDR_BAUD = 8'h10;
    localparam int CTRL_W = 9;
    localparam int C_SERIAL_PORT_ENABLE = 0;
    localparam int C_CLOCK_SOURCE_SELECT = 1;
    localparam int C_CPOL = 2;
    localparam int C_TRANSMIT_ENABLE = 3;
    localparam int C_TX9 = 4;
    localparam int C_TRANSMIT_NINTH_BIT = 5;
    localparam int C_RX9 = 6;
    localparam int C_SINGLE_RECEIVE_ENABLE = 7;
    localparam int C_CONTINUOUS_RECEIVE_ENABLE = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
    localparam logic [15:0] BAUD_RESET = 16'h0004;
    localparam logic [15:0] BAUD_ZERO = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // ****************
    // Character framing
    // ****************
    localparam int CHAR_W = 9;
    localparam logic [3:0] BITS8 = 4'h8;
    localparam logic [3:0] BITS9 = 4'h9;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam int FIFO_DEPTH = 2;
    localparam logic [1:0] FIFO_FULL = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TX = 3'b010,
        ST_RX = 3'b100
    } sshc_state_type;
endpackage : sshc_pkg

// [sshc_sync.sv]
// Two-flop synchroniser for the clock and data pin inputs
`timescale 1ns/1ns
module sshc_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pin levels in and out
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);
    logic [1:0] meta;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_bit
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    meta[g] <= 1'b0;
                    sync_out[g] <= 1'b0;
                end
                else
                begin
                    meta[g] <= async_in[g];
                    sync_out[g] <= meta[g];
                end
            end
        end
    endgenerate
endmodule : sshc_sync

// [sshc_peer.sv]
// Behavioural peer serial device on the shared data and clock lines
`timescale 1ns/1ns
module sshc_peer (
    // Wire levels
    input wire logic ck,
    input wire logic d_oe,
    input wire logic d_out,
    // Framing setup
    input wire logic cp,
    input wire logic [3:0] nb,
    // Peer drive
    output logic pck,
    output logic pd
);
    logic [8:0] q[$];
    logic [8:0] cur;
    logic [8:0] sh;
    logic [8:0] got;
    int ri;
    int ti;
    event got_ev;
    initial
    begin
        pck = 1'b0;
        pd = 1'b1;
        cur = 9'h000;
        sh = 9'h000;
        ri = 0;
        ti = 0;
    end
    always @(ck)
    begin
        if (ck !== cp && d_oe === 1'b0)
        begin
            if (ri == 0)
                cur = q.size() > 0 ? q.pop_front() : ~cur;
            pd <= cur[ri];
            ri = (ri + 1) % nb;
        end
        if (ck === cp && d_oe === 1'b1)
        begin
            sh = {d_out, sh[8:1]};
            ti = ti + 1;
            if (ti == nb)
            begin
                got = nb == 4'h9 ? sh : {1'b0, sh[8:1]};
                ti = 0;
                -> got_ev;
            end
        end
        // Hold time over: stop showing the last bit
        if (ck === cp && d_oe === 1'b0 && ri == 0)
            pd <= #40 ~pd;
    end
    task send(input int n);
        repeat (n)
        begin
            pck = ~cp;
            #62;
            pck = cp;
            #63;
        end
    endtask : send
    task clr;
        ri = 0;
        ti = 0;
        q.delete();
    endtask : clr
endmodule : sshc_peer

// [sshc_tb_top.sv]
// Self-checking bench for the synchronous serial engine
`timescale 1ns/1ns
module sshc_tb_top;
    logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp, cp, dp;
    logic ck_out, ck_oe, d_out, d_oe, pck, pd, ck_w, d_w;
    logic [1:0] htrans;
    logic [3:0] nb;
    logic [31:0] haddr, hwdata, hrdata, s;
    logic [8:0] w;
    logic [8:0] ws[3];
    logic [7:0] rxq[$];
    logic [8:0] txq[$];
    int mismatches, n_tests, nclk, cyc, v;
    // Resolved wire levels
    assign ck_w = ck_oe ? ck_out : pck;
    assign d_w = d_oe ? d_out : pd;
    sshc_top u_sshc_top (
        .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .clock_line_in(ck_w), .clock_line_out(ck_out),
        .clock_line_oe(ck_oe), .data_line_in(d_w), .data_line_out(d_out), .data_line_oe(d_oe)
    );
    sshc_peer u_sshc_peer (
        .ck(ck_w), .d_oe(d_oe), .d_out(d_out), .cp(cp), .nb(nb), .pck(pck), .pd(pd)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task chk(input string nm, input logic [31:0] sn, input logic [31:0] ex);
        n_tests++;
        if (sn !== ex)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, ex, sn);
        end
    endtask : chk
    task xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
        htrans <= sshc_pkg::HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        s = hrdata;
    endtask : xfer
    task ctrl(input logic [31:0] d);
        xfer(sshc_pkg::ADDR_CTRL, 1'b1, d);
        // Let the idle clock settle to the new polarity before the peer restarts its bit count
        repeat (2) @(posedge core_clk);
        u_sshc_peer.clr();
    endtask : ctrl
    task stat;
        xfer(sshc_pkg::ADDR_STAT, 1'b0, 32'h0);
    endtask : stat
    task waitst(input int b, input logic e);
        int i;
        i = 0;
        do
        begin
            stat();
            i++;
        end
        while (s[b] !== e && i < 3000);
    endtask : waitst
    // Results appear: read data phase of the receive register, or a frame at the peer
    always @(posedge core_clk)
    begin
        if (dp === 1'b1)
            chk("rxd", hrdata, {24'h000000, rxq.pop_front()});
        dp <= htrans == sshc_pkg::HTRANS_NONSEQ && !hwrite && haddr[7:0] == sshc_pkg::ADDR_RXD;
    end
    always @(u_sshc_peer.got_ev)
        chk("txword", {23'h000000, u_sshc_peer.got}, {23'h000000, txq.pop_front()});
    always @(posedge ck_out)
        nclk++;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end
    task results;
        $display("counts: checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, rst_n, cp, dp} = '0;
        {mismatches, n_tests, nclk, cyc} = '0;
        hsel = 1'b1;
        nb = 4'h8;
        void'($urandom(32'h56F7EBD1));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        xfer(sshc_pkg::ADDR_CTRL, 1'b0, 32'h0);
        chk("ctrl", s, 32'h0);
        xfer(sshc_pkg::ADDR_BAUD, 1'b0, 32'h0);
        chk("baud", s, {16'h0000, sshc_pkg::BAUD_RESET});
        xfer(8'h14, 1'b0, 32'h0);
        chk("unmapped", s, 32'h0);
        chk("oe", {ck_oe, d_oe}, 32'h0);
        chk("hresp", hresp, 32'h0);
        $display("test reset done");
        // Host transmit, both polarities, eight then nine bits
        for (int i = 0; i < 2; i++)
        begin
            cp <= i[0];
            nb <= i[0] ? 4'h9 : 4'h8;
            ctrl(i[0] ? 32'h03F : 32'h00B);
            chk("txoe", {ck_oe, d_oe}, 32'h3);
            for (int k = 0; k < 2; k++)
            begin
                w = {i[0], 8'($urandom)};
                txq.push_back(w);
                xfer(sshc_pkg::ADDR_TXD, 1'b1, {23'h000000, w});
                stat();
                chk("load", s[4:3], k ? 32'h3 : 32'h2);
            end
            waitst(4, 1'b0);
            chk("idle", ck_out, i[0]);
        end
        $display("test host transmit done");
        cp <= 1'b0;
        nb <= 4'h8;
        ctrl(32'h083);
        w = {1'b0, 8'($urandom)};
        u_sshc_peer.q.push_back(w);
        rxq.push_back(w[7:0]);
        nclk = 0;
        chk("rxoe", d_oe, 32'h0);
        waitst(2, 1'b1);
        chk("clocks", nclk, 32'd8);
        xfer(sshc_pkg::ADDR_CTRL, 1'b0, 32'h0);
        chk("single_receive_enable", s[7], 32'h0);
        xfer(sshc_pkg::ADDR_RXD, 1'b0, 32'h0);
        stat();
        chk("flag", s[2], 32'h0);
        $display("test single receive done");
        nb <= 4'h9;
        ctrl(32'h1C3);
        for (int k = 0; k < 3; k++)
        begin
            ws[k] = 9'($urandom);
            u_sshc_peer.q.push_back(ws[k]);
            if (k < 2)
                rxq.push_back(ws[k][7:0]);
        end
        waitst(1, 1'b1);
        xfer(sshc_pkg::ADDR_CTRL, 1'b0, 32'h0);
        chk("both", s[8:7], 32'h2);
        for (int k = 0; k < 2; k++)
        begin
            stat();
            chk("ninth", s[0], ws[k][8]);
            xfer(sshc_pkg::ADDR_RXD, 1'b0, 32'h0);
        end
        stat();
        chk("overrun", s[2:1], 32'h1);
        ctrl(32'h043);
        stat();
        chk("ovclr", {ck_out, s[1]}, 32'h0);
        v = nclk;
        repeat (30) @(posedge core_clk);
        chk("stopped", nclk, v);
        $display("test continuous receive done");
        nb <= 4'h8;
        ctrl(32'h101);
        chk("ckoe", ck_oe, 32'h0);
        w = {1'b0, 8'($urandom)};
        u_sshc_peer.q.push_back(w);
        rxq.push_back(w[7:0]);
        u_sshc_peer.send(8);
        @(posedge core_clk);
        waitst(2, 1'b1);
        xfer(sshc_pkg::ADDR_RXD, 1'b0, 32'h0);
        ctrl(32'h009);
        w = {1'b0, 8'($urandom)};
        txq.push_back(w);
        xfer(sshc_pkg::ADDR_TXD, 1'b1, {23'h000000, w});
        u_sshc_peer.send(8);
        @(posedge core_clk);
        $display("test client done");
        ctrl(32'h0);
        stat();
        chk("spenoff", s[4:0], 32'h0);
        $display("test disable done");
        results();
    end
endmodule : sshc_tb_top
